// File: dv/fpsc_iu_model.sv
// Purpose: integer unit model issuing and completing fp instructions
// Assumes: every task is entered just after a falling edge of core_clk
// Notes: completion data is inverted once released so stale values show
`timescale 1ns/1ps

module fpsc_iu_model (
    // clock
    input wire logic core_clk,
    // instruction start
    output logic op_start,
    output logic op_slot,
    output fpsc_pkg::fpsc_op_t op_kind,
    output logic [31:0] op_addr,
    // instruction completion
    output logic op_done,
    output logic done_slot,
    output logic [3:0] done_cc,
    output logic [7:0] done_exc,
    output logic done_quot_vld,
    output logic [7:0] done_quot
);
    initial begin
        op_start = 1'b0;
        op_slot = 1'b0;
        op_kind = fpsc_pkg::FPSC_OP_MOVE_CTL;
        op_addr = 32'h0;
        op_done = 1'b0;
        done_slot = 1'b0;
        done_cc = 4'h0;
        done_exc = 8'h0;
        done_quot_vld = 1'b0;
        done_quot = 8'h0;
    end

    // ======================================================
    // start: one-cycle strobe, slot held so op_ready stays meaningful
    task automatic issue(input logic slot, input fpsc_pkg::fpsc_op_t kind,
                         input logic [31:0] addr);
        @(negedge core_clk);
        op_start = 1'b1;
        op_slot = slot;
        op_kind = kind;
        op_addr = addr;
        @(negedge core_clk);
        op_start = 1'b0;
        op_addr = ~addr;
    endtask

    // ======================================================
    // completion: data is garbage outside the strobe cycle
    task automatic finish(input logic slot, input logic [3:0] cc,
                          input logic [7:0] trap_cause_byte, input logic qv,
                          input logic [7:0] q);
        @(negedge core_clk);
        op_done = 1'b1;
        done_slot = slot;
        done_cc = cc;
        done_exc = trap_cause_byte;
        done_quot_vld = qv;
        done_quot = q;
        @(negedge core_clk);
        op_done = 1'b0;
        done_cc = ~cc;
        done_exc = ~trap_cause_byte;
        done_quot_vld = 1'b0;
        done_quot = ~q;
    endtask
endmodule

// File: dv/fpsc_regs_bench.sv
// Purpose: self-checking bench for the fp control and status bank
// Assumes: inputs change on falling edges only
// Notes: expected values are worked out from the field layout by hand
`timescale 1ns/1ps
`include "fpsc_map.svh"

module fpsc_regs_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic null_restore = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic op_start, op_slot, op_ready, op_done, done_slot, done_quot_vld;
    fpsc_pkg::fpsc_op_t op_kind;
    logic [31:0] op_addr;
    logic [3:0] done_cc;
    logic [7:0] done_exc, done_quot, trap_enable;
    logic [1:0] slot_busy, rounding_mode_field, rounding_width_field;
    logic trap_req;
    logic dreg_wr = 1'b0;
    logic [2:0] dreg_idx = 3'h0;
    fpsc_pkg::fpsc_fmt_t dreg_fmt = fpsc_pkg::FPSC_FMT_EXT;
    logic [79:0] dreg_wdata = 80'h0;
    logic [2:0] dreg_rd_idx = 3'h0;
    logic [79:0] dreg_rdata;
    integer failures = 0;
    integer samples_checked = 0;
    // cause byte in, expected sticky byte out
    logic [7:0] exc_tab [9] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h0a, 8'h04,
                                8'h02, 8'h01, 8'h80};
    logic [7:0] stk_tab [9] = '{8'h80, 8'h80, 8'h48, 8'h00, 8'h28, 8'h10,
                                8'h08, 8'h08, 8'h00};

    always #50 core_clk = ~core_clk;

    fpsc_regs u_fpsc_regs (.core_clk(core_clk), .rst_n(rst_n),
        .null_restore(null_restore), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .op_start(op_start), .op_slot(op_slot), .op_kind(op_kind),
        .op_addr(op_addr), .op_ready(op_ready), .op_done(op_done),
        .done_slot(done_slot), .done_cc(done_cc), .done_exc(done_exc),
        .done_quot_vld(done_quot_vld), .done_quot(done_quot),
        .slot_busy(slot_busy), .trap_req(trap_req), .dreg_wr(dreg_wr),
        .dreg_idx(dreg_idx), .dreg_fmt(dreg_fmt), .dreg_wdata(dreg_wdata),
        .dreg_rd_idx(dreg_rd_idx), .dreg_rdata(dreg_rdata),
        .trap_enable(trap_enable),
        .rounding_mode_field(rounding_mode_field),
        .rounding_width_field(rounding_width_field));

    fpsc_iu_model u_fpsc_iu_model (.core_clk(core_clk),
        .op_start(op_start), .op_slot(op_slot), .op_kind(op_kind),
        .op_addr(op_addr), .op_done(op_done), .done_slot(done_slot),
        .done_cc(done_cc), .done_exc(done_exc),
        .done_quot_vld(done_quot_vld), .done_quot(done_quot));

    // ======================================================
    // comparison, verdict and access tasks
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [1:0] sel, input logic [31:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic expect_reg(input logic [1:0] sel, input logic [31:0] exp);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_sel = sel;
        @(negedge core_clk);
        reg_rd = 1'b0;
        check(reg_rdata, exp);
    endtask

    task automatic dreg_put(input logic [2:0] idx,
                            input fpsc_pkg::fpsc_fmt_t fmt,
                            input logic [79:0] d);
        @(negedge core_clk);
        dreg_wr = 1'b1;
        dreg_idx = idx;
        dreg_fmt = fmt;
        dreg_wdata = d;
        @(negedge core_clk);
        dreg_wr = 1'b0;
        dreg_wdata = ~d;
    endtask

    task automatic dreg_expect(input logic [2:0] idx, input logic [79:0] exp);
        @(negedge core_clk);
        dreg_rd_idx = idx;
        @(negedge core_clk);
        check(dreg_rdata, exp);
    endtask

    // hang guard: whole run is far shorter than this
    initial begin
        repeat (20000) @(posedge core_clk);
        failures = failures + 1;
        end_of_test();
    end

    // ======================================================
    // main sequence
    initial begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        expect_reg(`FPSC_SEL_CTL, 32'h0);
        expect_reg(`FPSC_SEL_STS, 32'h0);
        expect_reg(`FPSC_SEL_FAR, 32'h0);
        for (int i = 0; i < 8; i++) begin
            dreg_expect(3'(i), `FPSC_NAN_INIT);
        end
        reg_write(`FPSC_SEL_CTL, 32'hffff_a5f0);
        expect_reg(`FPSC_SEL_CTL, 32'h0000_a5f0);
        check(trap_enable, 8'ha5);
        check({rounding_mode_field, rounding_width_field}, 4'hf);
        reg_write(2'h3, 32'hffff_ffff);
        expect_reg(2'h3, 32'h0);
        reg_write(`FPSC_SEL_STS, 32'hffff_ffff);
        expect_reg(`FPSC_SEL_STS, 32'hffff_ffff);
        // trap only on overflow from here on
        reg_write(`FPSC_SEL_CTL, 32'h0000_1000);
        reg_write(`FPSC_SEL_STS, 32'h0000_ff00);
        u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_1234);
        check(slot_busy, 2'b01);
        check(op_ready, 1'b0);
        expect_reg(`FPSC_SEL_STS, 32'h0);
        expect_reg(`FPSC_SEL_FAR, 32'h0000_1234);
        u_fpsc_iu_model.finish(1'b0, 4'h8, 8'h10, 1'b1, 8'h85);
        check(trap_req, 1'b1);
        expect_reg(`FPSC_SEL_STS, 32'h0885_1048);
        // untrappable ops: nothing in status or fault address moves
        u_fpsc_iu_model.issue(1'b1, fpsc_pkg::FPSC_OP_MOVE_CTL, 32'h0000_9999);
        u_fpsc_iu_model.finish(1'b1, 4'h3, 8'h01, 1'b0, 8'h00);
        check(trap_req, 1'b0);
        expect_reg(`FPSC_SEL_STS, 32'h0885_1048);
        u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_MOVE_MULT, 32'h0000_7777);
        u_fpsc_iu_model.finish(1'b0, 4'h3, 8'h00, 1'b0, 8'h00);
        expect_reg(`FPSC_SEL_FAR, 32'h0000_1234);
        for (int i = 0; i < 9; i++) begin
            reg_write(`FPSC_SEL_STS, 32'h0);
            u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_0040);
            u_fpsc_iu_model.finish(1'b0, 4'h0, exc_tab[i], 1'b0, 8'h00);
            check(trap_req, exc_tab[i][4]);
            expect_reg(`FPSC_SEL_STS, {16'h0, exc_tab[i], stk_tab[i]});
        end
        u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_0044);
        u_fpsc_iu_model.finish(1'b0, 4'h2, 8'h04, 1'b0, 8'h00);
        u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_0048);
        u_fpsc_iu_model.finish(1'b0, 4'h2, 8'h40, 1'b0, 8'h00);
        expect_reg(`FPSC_SEL_STS, 32'h0200_4090);
        u_fpsc_iu_model.issue(1'b1, fpsc_pkg::FPSC_OP_MOVE_OUT, 32'h0000_5678);
        u_fpsc_iu_model.finish(1'b1, 4'h1, 8'h20, 1'b0, 8'h00);
        expect_reg(`FPSC_SEL_STS, 32'h0200_2090);
        expect_reg(`FPSC_SEL_FAR, 32'h0000_5678);
        // two instructions in flight, newest one owns the cause byte
        reg_write(`FPSC_SEL_STS, 32'h0);
        u_fpsc_iu_model.issue(1'b0, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_0100);
        u_fpsc_iu_model.issue(1'b1, fpsc_pkg::FPSC_OP_ARITH, 32'h0000_0200);
        check(slot_busy, 2'b11);
        expect_reg(`FPSC_SEL_FAR, 32'h0000_0200);
        u_fpsc_iu_model.finish(1'b1, 4'h4, 8'h02, 1'b0, 8'h00);
        u_fpsc_iu_model.finish(1'b0, 4'h4, 8'h00, 1'b0, 8'h00);
        check(slot_busy, 2'b00);
        expect_reg(`FPSC_SEL_STS, 32'h0400_0208);
        dreg_put(3'h3, fpsc_pkg::FPSC_FMT_SGL, 80'h3f80_0000);
        dreg_expect(3'h3, 80'h3fff_8000_0000_0000_0000);
        dreg_put(3'h4, fpsc_pkg::FPSC_FMT_DBL, 80'hc000_0000_0000_0000);
        dreg_expect(3'h4, 80'hc000_8000_0000_0000_0000);
        dreg_put(3'h5, fpsc_pkg::FPSC_FMT_EXT, 80'hc000_a000_0000_0000_0001);
        dreg_expect(3'h5, 80'hc000_a000_0000_0000_0001);
        @(negedge core_clk);
        null_restore = 1'b1;
        @(negedge core_clk);
        null_restore = 1'b0;
        expect_reg(`FPSC_SEL_CTL, 32'h0);
        check(trap_enable, 8'h00);
        expect_reg(`FPSC_SEL_STS, 32'h0);
        expect_reg(`FPSC_SEL_FAR, 32'h0);
        dreg_expect(3'h3, `FPSC_NAN_INIT);
        end_of_test();
    end
endmodule

// File: hw/fpsc_map.svh
// Purpose: constants for the fp control and status register bank
// Assumes: 32-bit register moves, 80-bit extended data registers
// Notes: field positions follow the status/control register layout
// Contract
// - Reset or null restore loads all eight data registers with positive quiet NaN.
// - Every external operand becomes extended precision before storage or use.
// - Control register bits 31-16 read zero and ignore writes.
// - Reset or null restore clears control register, giving IEEE 754 defaults.
// - Trap enable byte has one bit per exception class, each enabling its trap.
// - Mode byte holds rounding mode and rounding width; zeros give defaults.
// - Status register holds condition, quotient, trap cause, sticky bytes; all RW.
// - Reset or null restore clears the whole status register.
// - Arithmetic instructions on data registers update the four condition bits.
// - Move out, move multiple and control moves leave condition bits alone.
// - Quotient byte holds seven low quotient bits and sign until software clears.
// - Trap cause byte clears at start of trap-capable ops, else unchanged.
// - Most ops, moves excluded, OR a trap-cause-derived value into sticky byte.
// - Sticky byte clears only by status write, reset or null restore.
// - Sticky byte writes never raise nor suppress an exception.
// - Sticky bits accumulate by the fixed OR/AND equations from trap cause bits.
// - Trap-capable instructions load fault address register with their address first.
// - Control moves and multiple moves leave fault address register unchanged.
// - Reset or null restore clears fault address register to zero.
// - Unit runs beside integer unit with two fp instructions in flight.
`ifndef FPSC_MAP_SVH
`define FPSC_MAP_SVH

// ==========================================================
// register select codes
`define FPSC_SEL_CTL 2'h0
`define FPSC_SEL_STS 2'h1
`define FPSC_SEL_FAR 2'h2

// ==========================================================
// status register fields
`define FPSC_STS_CC_LSB 24
`define FPSC_STS_QUOT_LSB 16
`define FPSC_STS_EXC_LSB 8
`define FPSC_STS_STICKY_FAULT_BYTE_LSB 0
`define FPSC_STICKY_FAULT_BYTE_OVERFLOW_FLAG 6
// trap cause bit positions inside its byte
`define FPSC_EXC_SIGNALING_NAN_FLAG 6
`define FPSC_EXC_OPERAND_ERROR_FLAG 5
`define FPSC_EXC_OVERFLOW_FLAG 4
`define FPSC_EXC_UNDERFLOW_FLAG 3
`define FPSC_EXC_DZ 2
`define FPSC_EXC_IMPRECISE_OP_FLAG 1
`define FPSC_EXC_IMPRECISE_INPUT_FLAG 0

// ==========================================================
// control register fields and reset values
`define FPSC_CTL_EN_LSB 8
`define FPSC_CTL_WIDTH_LSB 6
`define FPSC_CTL_RND_LSB 4
`define FPSC_CTL_RESET 16'h0000
`define FPSC_STS_RESET 32'h0000_0000
`define FPSC_FAR_RESET 32'h0000_0000
`define FPSC_NAN_INIT 80'h7fff_c000_0000_0000_0000

// ==========================================================
// exponent rebias to extended precision
`define FPSC_SGL_REBIAS 15'h3f80
`define FPSC_SGL_DENORM 15'h3f81
`define FPSC_DBL_REBIAS 15'h3c00
`define FPSC_DBL_DENORM 15'h3c01
`define FPSC_EXP_MAX 15'h7fff

`endif

// File: hw/fpsc_pkg.sv
// Purpose: types shared by the fp control and status bank
// Assumes: nothing beyond the map header
// Notes: op kind decides trap, condition and sticky behaviour
package fpsc_pkg;

    // ======================================================
    // instruction classes issued by the integer unit
    typedef enum logic [2:0] {
        FPSC_OP_ARITH,
        FPSC_OP_MOVE_IN,
        FPSC_OP_MOVE_OUT,
        FPSC_OP_MOVE_MULT,
        FPSC_OP_MOVE_CTL
    } fpsc_op_t;

    // ======================================================
    // external operand formats
    typedef enum logic [1:0] {
        FPSC_FMT_SGL,
        FPSC_FMT_DBL,
        FPSC_FMT_EXT
    } fpsc_fmt_t;

endpackage

// File: hw/fpsc_regs.sv
// Purpose: fp control, status, fault address and data register bank
// Assumes: integer unit drives all inputs on core_clk
// Notes: two instruction slots tracked; register reads land a cycle later
`timescale 1ns/1ps
`include "fpsc_map.svh"

module fpsc_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic null_restore,
    // control register moves
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_sel,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // instruction start
    input wire logic op_start,
    input wire logic op_slot,
    input wire fpsc_pkg::fpsc_op_t op_kind,
    input wire logic [31:0] op_addr,
    output logic op_ready,
    // instruction completion
    input wire logic op_done,
    input wire logic done_slot,
    input wire logic [3:0] done_cc,
    input wire logic [7:0] done_exc,
    input wire logic done_quot_vld,
    input wire logic [7:0] done_quot,
    output logic [1:0] slot_busy,
    output logic trap_req,
    // data registers
    input wire logic dreg_wr,
    input wire logic [2:0] dreg_idx,
    input wire fpsc_pkg::fpsc_fmt_t dreg_fmt,
    input wire logic [79:0] dreg_wdata,
    input wire logic [2:0] dreg_rd_idx,
    output logic [79:0] dreg_rdata,
    // mode outputs to the datapath
    output logic [7:0] trap_enable,
    output logic [1:0] rounding_mode_field,
    output logic [1:0] rounding_width_field
);

    // ======================================================
    // reset release
    logic [1:0] rst_sync_r;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_r[1];

    // ======================================================
    // declarations
    logic [15:0] fp_control_reg_r;
    logic [31:0] fp_status_reg_r;
    logic [31:0] fp_status_nxt;
    logic [31:0] fp_fault_address_reg_r;
    logic [79:0] fp_data_regs_r [8];
    logic [1:0] busy_w;
    fpsc_pkg::fpsc_op_t kind_w [2];
    fpsc_pkg::fpsc_op_t done_kind;
    logic latest_r;
    logic start_ok;
    logic done_ok;
    logic start_trap;
    logic wr_sts;
    logic [7:0] sticky_fault_byte_add;

    // ======================================================
    // instruction class properties
    function automatic logic can_trap(input fpsc_pkg::fpsc_op_t k);
        can_trap = (k == fpsc_pkg::FPSC_OP_ARITH) ||
                   (k == fpsc_pkg::FPSC_OP_MOVE_IN) ||
                   (k == fpsc_pkg::FPSC_OP_MOVE_OUT);
    endfunction

    function automatic logic sets_cc(input fpsc_pkg::fpsc_op_t k);
        sets_cc = (k == fpsc_pkg::FPSC_OP_ARITH) ||
                  (k == fpsc_pkg::FPSC_OP_MOVE_IN);
    endfunction

    function automatic logic accrues(input fpsc_pkg::fpsc_op_t k);
        accrues = (k == fpsc_pkg::FPSC_OP_ARITH);
    endfunction

    // operand conversion; denormals become unnormals of equal value
    function automatic logic [79:0] to_ext(input fpsc_pkg::fpsc_fmt_t f,
                                           input logic [79:0] d);
        logic [7:0] se;
        logic [10:0] de;
        se = d[30:23];
        de = d[62:52];
        to_ext = d;
        unique case (f)
            fpsc_pkg::FPSC_FMT_SGL: begin
                if (se == 8'h00 && d[22:0] == 23'h0) begin
                    to_ext = {d[31], 79'h0};
                end else if (se == 8'hff) begin
                    to_ext = {d[31], `FPSC_EXP_MAX, 1'b1, d[22:0], 40'h0};
                end else if (se == 8'h00) begin
                    to_ext = {d[31], `FPSC_SGL_DENORM, 1'b0, d[22:0], 40'h0};
                end else begin
                    to_ext = {d[31], 15'({7'h0, se}) + `FPSC_SGL_REBIAS,
                              1'b1, d[22:0], 40'h0};
                end
            end
            fpsc_pkg::FPSC_FMT_DBL: begin
                if (de == 11'h000 && d[51:0] == 52'h0) begin
                    to_ext = {d[63], 79'h0};
                end else if (de == 11'h7ff) begin
                    to_ext = {d[63], `FPSC_EXP_MAX, 1'b1, d[51:0], 11'h0};
                end else if (de == 11'h000) begin
                    to_ext = {d[63], `FPSC_DBL_DENORM, 1'b0, d[51:0], 11'h0};
                end else begin
                    to_ext = {d[63], 15'({4'h0, de}) + `FPSC_DBL_REBIAS,
                              1'b1, d[51:0], 11'h0};
                end
            end
            fpsc_pkg::FPSC_FMT_EXT: begin
                to_ext = d;
            end
        endcase
    endfunction

    // ======================================================
    // instruction slots
    // a slot accepts a new instruction only while it is idle
    assign op_ready = ~busy_w[op_slot];
    assign start_ok = op_start & op_ready;
    assign done_ok = op_done & busy_w[done_slot];
    assign done_kind = kind_w[done_slot];
    assign start_trap = start_ok & can_trap(op_kind);
    assign slot_busy = busy_w;

    for (genvar i = 0; i < 2; i++) begin : g_slot
        logic busy_q;
        fpsc_pkg::fpsc_op_t kind_q;
        always_ff @(posedge core_clk or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                busy_q <= 1'b0;
                kind_q <= fpsc_pkg::FPSC_OP_ARITH;
            end else if (null_restore) begin
                busy_q <= 1'b0;
            end else if (start_ok && op_slot == 1'(i)) begin
                busy_q <= 1'b1;
                kind_q <= op_kind;
            end else if (done_ok && done_slot == 1'(i)) begin
                busy_q <= 1'b0;
            end
        end
        assign busy_w[i] = busy_q;
        assign kind_w[i] = kind_q;
    end

    // the trap cause byte only reports the newest trap-capable slot
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            latest_r <= 1'b0;
        end else if (start_trap) begin
            latest_r <= op_slot;
        end
    end

    // ======================================================
    // control register
    // upper half not stored
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fp_control_reg_r <= `FPSC_CTL_RESET;
        end else if (null_restore) begin
            fp_control_reg_r <= `FPSC_CTL_RESET;
        end else if (reg_wr && reg_sel == `FPSC_SEL_CTL) begin
            fp_control_reg_r <= reg_wdata[15:0];
        end
    end

    assign trap_enable = fp_control_reg_r[`FPSC_CTL_EN_LSB +: 8];
    assign rounding_mode_field = fp_control_reg_r[`FPSC_CTL_RND_LSB +: 2];
    assign rounding_width_field = fp_control_reg_r[`FPSC_CTL_WIDTH_LSB +: 2];

    // ======================================================
    // status register
    assign wr_sts = reg_wr && reg_sel == `FPSC_SEL_STS;

    assign sticky_fault_byte_add = {done_exc[`FPSC_EXC_SIGNALING_NAN_FLAG] | done_exc[`FPSC_EXC_OPERAND_ERROR_FLAG],
                       done_exc[`FPSC_EXC_OVERFLOW_FLAG],
                       done_exc[`FPSC_EXC_UNDERFLOW_FLAG] & done_exc[`FPSC_EXC_IMPRECISE_OP_FLAG],
                       done_exc[`FPSC_EXC_DZ],
                       done_exc[`FPSC_EXC_IMPRECISE_INPUT_FLAG] | done_exc[`FPSC_EXC_IMPRECISE_OP_FLAG] |
                       done_exc[`FPSC_EXC_OVERFLOW_FLAG],
                       3'h0};

    // hardware updates are applied after the software write so they win
    always_comb begin
        fp_status_nxt = fp_status_reg_r;
        if (wr_sts) begin
            fp_status_nxt = reg_wdata;
        end
        if (start_trap) begin
            fp_status_nxt[`FPSC_STS_EXC_LSB +: 8] = 8'h00;
        end
        if (done_ok) begin
            if (sets_cc(done_kind)) begin
                fp_status_nxt[`FPSC_STS_CC_LSB +: 4] = done_cc;
            end
            if (done_quot_vld) begin
                fp_status_nxt[`FPSC_STS_QUOT_LSB +: 8] = done_quot;
            end
            if (can_trap(done_kind) && done_slot == latest_r &&
                !start_trap) begin
                fp_status_nxt[`FPSC_STS_EXC_LSB +: 8] = done_exc;
            end
            if (accrues(done_kind)) begin
                fp_status_nxt[`FPSC_STS_STICKY_FAULT_BYTE_LSB +: 8] =
                    fp_status_nxt[`FPSC_STS_STICKY_FAULT_BYTE_LSB +: 8] | sticky_fault_byte_add;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fp_status_reg_r <= `FPSC_STS_RESET;
        end else if (null_restore) begin
            fp_status_reg_r <= `FPSC_STS_RESET;
        end else begin
            fp_status_reg_r <= fp_status_nxt;
        end
    end

    // trap from cause and enable only, sticky never looked at
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            trap_req <= 1'b0;
        end else begin
            trap_req <= done_ok && !null_restore && can_trap(done_kind) &&
                        |(done_exc & trap_enable);
        end
    end

    // ======================================================
    // fault address register
    // load on trap-capable start, otherwise on a software write
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            fp_fault_address_reg_r <= `FPSC_FAR_RESET;
        end else if (null_restore) begin
            fp_fault_address_reg_r <= `FPSC_FAR_RESET;
        end else if (start_trap) begin
            fp_fault_address_reg_r <= op_addr;
        end else if (reg_wr && reg_sel == `FPSC_SEL_FAR) begin
            fp_fault_address_reg_r <= reg_wdata;
        end
    end

    // ======================================================
    // register read port, unmapped select reads zero
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_sel)
                `FPSC_SEL_CTL: reg_rdata <= {16'h0000, fp_control_reg_r};
                `FPSC_SEL_STS: reg_rdata <= fp_status_reg_r;
                `FPSC_SEL_FAR: reg_rdata <= fp_fault_address_reg_r;
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================
    // data registers
    // quiet NaN on clear, conversion on write
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int j = 0; j < 8; j++) begin
                fp_data_regs_r[j] <= `FPSC_NAN_INIT;
            end
        end else if (null_restore) begin
            for (int j = 0; j < 8; j++) begin
                fp_data_regs_r[j] <= `FPSC_NAN_INIT;
            end
        end else if (dreg_wr) begin
            fp_data_regs_r[dreg_idx] <= to_ext(dreg_fmt, dreg_wdata);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dreg_rdata <= 80'h0;
        end else begin
            dreg_rdata <= fp_data_regs_r[dreg_rd_idx];
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    a_nan_restore: assert property (
        null_restore |=> fp_data_regs_r[7] == `FPSC_NAN_INIT &&
                         fp_data_regs_r[0] == `FPSC_NAN_INIT)
        else $error("data register not NaN after restore");
    a_ctl_upper_zero: assert property (
        reg_rd && reg_sel == `FPSC_SEL_CTL |=> reg_rdata[31:16] == 16'h0)
        else $error("control upper half not zero");
    a_sts_cleared: assert property (
        null_restore |=> fp_status_reg_r == 32'h0 &&
                         fp_control_reg_r == 16'h0)
        else $error("status or control not cleared");
    a_exc_start_clr: assert property (
        start_trap && !done_ok && !null_restore
        |=> fp_status_reg_r[`FPSC_STS_EXC_LSB +: 8] == 8'h00)
        else $error("trap cause not cleared at start");
    a_cc_kept: assert property (
        done_ok && !sets_cc(done_kind) && !wr_sts && !null_restore
        |=> $stable(fp_status_reg_r[`FPSC_STS_CC_LSB +: 4]))
        else $error("condition byte changed by a move");
    a_sticky_fault_byte_sticky: assert property (
        !wr_sts && !null_restore
        |=> (($past(fp_status_reg_r[7:0]) & ~fp_status_reg_r[7:0]) == 8'h0))
        else $error("sticky bit dropped without a write");
    a_sticky_fault_byte_overflow_flag: assert property (
        done_ok && accrues(done_kind) && done_exc[`FPSC_EXC_OVERFLOW_FLAG] &&
        !null_restore |=> fp_status_reg_r[`FPSC_STICKY_FAULT_BYTE_OVERFLOW_FLAG])
        else $error("overflow not accrued");
    a_trap_gate: assert property (
        done_ok && (done_exc & trap_enable) == 8'h0 |=> !trap_req)
        else $error("trap without an enabled cause");
    a_far_load: assert property (
        start_trap && !null_restore
        |=> fp_fault_address_reg_r == $past(op_addr))
        else $error("fault address not loaded");
    a_far_held: assert property (
        start_ok && !can_trap(op_kind) && !reg_wr && !null_restore
        |=> $stable(fp_fault_address_reg_r))
        else $error("fault address changed by a move");
    a_far_cleared: assert property (
        null_restore |=> fp_fault_address_reg_r == 32'h0)
        else $error("fault address not cleared");

    c_two_in_flight: cover property (busy_w == 2'h3);
    c_trap_raised: cover property (trap_req);
    c_sticky_set: cover property (fp_status_reg_r[7:3] != 5'h0);

endmodule
